// ===== inc/fmrx_params.svh
// Offsets, bit positions, reset values and sizes of the receiver register bank.
// Assumes a 4-bit parallel address and 8-bit data on the host side.
`ifndef FMRX_PARAMS_SVH
`define FMRX_PARAMS_SVH

`define FMRX_OFF_DATA 4'h0
`define FMRX_OFF_STAT 4'h1
`define FMRX_OFF_NUM 4'h2
`define FMRX_OFF_RSVD_LO 4'h3
`define FMRX_OFF_CTRL_TWO 4'h5
`define FMRX_OFF_CRC 4'h6

`define FMRX_CTRL_RSVD 7
`define FMRX_CTRL_BSR 6
`define FMRX_CTRL_ACKPOL 5
`define FMRX_CTRL_REQPOL 4
`define FMRX_CTRL_RDYT 3
`define FMRX_CTRL_VOUT 2
`define FMRX_CTRL_DMARD 1
`define FMRX_CTRL_DMAEN 0

`define FMRX_STAT_VCORR 7
`define FMRX_STAT_BSYNC 6
`define FMRX_STAT_FSYNC 5
`define FMRX_STAT_ERR 4
`define FMRX_STAT_PARITY 3
`define FMRX_STAT_HEAD 2
`define FMRX_STAT_CRC 1
`define FMRX_STAT_RTIME 0

`define FMRX_CTRL_RST 8'h00
`define FMRX_STAT_RST 8'h02
`define FMRX_NUM_RST 8'h00
`define FMRX_CRC_RST 16'h0000
`define FMRX_CRC_POLY 16'h1021

`define FMRX_DATA_W 8
`define FMRX_FIFO_DEPTH 32

`endif

// ===== inc/fmrx_pkg.sv
// Types shared by the receiver register bank and its self-checking bench.
// Assumes fmrx_params.svh for all numeric constants.
package fmrx_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] crc_t;
    typedef enum logic [2:0] {
        RDY_IDLE = 3'b001,
        RDY_WAIT = 3'b010,
        RDY_DRIVE = 3'b100
    } rdy_state_e;
endpackage : fmrx_pkg

// ===== inc/fifo_if.sv
// Valid/ready carrier between the register bank and its data FIFO.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 8);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    modport user (output push_valid, output push_data, input push_ready,
                  input pop_valid, input pop_data, output pop_ready);
    modport store (input push_valid, input push_data, output push_ready,
                   output pop_valid, output pop_data, input pop_ready);
endinterface : fifo_if

// ===== verilog/data_fifo.sv
// Synchronous FIFO holding corrected data bytes for the host.
// Assumes the user side honours push_ready and pop_valid.
`timescale 1ns/1ps
module data_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    fifo_if.store bus
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic full;
    logic empty;
    logic do_push;
    logic do_pop;

    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign bus.push_ready = !full;
    assign bus.pop_valid = !empty;
    assign bus.pop_data = mem[rd_ptr[AW-1:0]];
    assign do_push = bus.push_valid && !full;
    assign do_pop = bus.pop_ready && !empty;

    always_ff @(posedge clk_i)
    begin
        if (do_push)
        begin
            mem[wr_ptr[AW-1:0]] <= bus.push_data;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    property p_no_overflow;
        @(posedge clk_i) disable iff (rst_i)
        full |=> (wr_ptr == $past(wr_ptr)) || do_pop || $past(do_pop);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo pushed while full");
endmodule : data_fifo

// ===== verilog/fm_data_rx_ctrl_status_regs.sv
// Host register bank of the FM multiplex data receiver: control two,
// group CRC input, corrected data port, status and block number.
// Assumes a synchronous parallel host bus with one-cycle strobes, a
// receiver core that streams corrected bytes and pulses block_start_i.
`timescale 1ns/1ps
`include "fmrx_params.svh"

module fm_data_rx_ctrl_status_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic interface_select_i,
    input wire logic [3:0] addr_i,
    input wire fmrx_pkg::byte_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output fmrx_pkg::byte_t rdata_o,
    output logic rdy_o,
    input wire logic dma_acknowledge_i,
    output logic dma_request_o,
    input wire logic ser_crc_valid_i,
    input wire fmrx_pkg::byte_t ser_crc_data_i,
    input wire logic ser_read_i,
    input wire logic group_crc_reset_i,
    output logic group_crc_ok_o,
    output logic block_sync_reset_o,
    input wire fmrx_pkg::byte_t core_data_i,
    input wire logic core_valid_i,
    output logic core_ready_o,
    input wire logic block_start_i,
    input wire logic vertical_slot_i,
    input wire logic vertical_done_i,
    input wire logic vertical_corrected_i,
    input wire logic block_sync_i,
    input wire logic frame_sync_i,
    input wire logic uncorrectable_i,
    input wire logic parity_block_i,
    input wire logic head_block_i,
    input wire logic realtime_block_i,
    input wire fmrx_pkg::byte_t block_number_i,
    output logic int_n_o
);
    import fmrx_pkg::*;

    byte_t control_two;
    byte_t stat_q;
    byte_t output_block_number;
    crc_t group_crc;
    rdy_state_e rdy_state;
    rdy_state_e next_rdy_state;
    logic drop_block;
    logic suppress;
    logic accept;
    logic parallel;
    logic ack_active;
    logic dma_strobe;
    logic host_pop;
    logic crc_load;
    byte_t crc_byte;
    byte_t receive_status;
    byte_t next_rdata;

    fifo_if #(.W(`FMRX_DATA_W)) dq ();

    data_fifo #(
        .WIDTH(`FMRX_DATA_W),
        .DEPTH(`FMRX_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bus(dq.store)
    );

    function automatic crc_t crc_step(input crc_t crc, input byte_t data);
        crc_t c;
        c = crc;
        for (int i = 7; i >= 0; i--)
        begin
            if (c[15] ^ data[i])
            begin
                c = {c[14:0], 1'b0} ^ `FMRX_CRC_POLY;
            end
            else
            begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : crc_step

    assign parallel = !interface_select_i;

    // Control register two, write only
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            control_two <= `FMRX_CTRL_RST;
        end
        else if (wr_i && parallel && addr_i == `FMRX_OFF_CTRL_TWO)
        begin
            control_two <= wdata_i;
            control_two[`FMRX_CTRL_RSVD] <= 1'b0;
        end
    end

    assign block_sync_reset_o = control_two[`FMRX_CTRL_BSR];

    // Polarity applied only in parallel mode
    assign ack_active = parallel
        && (dma_acknowledge_i == control_two[`FMRX_CTRL_ACKPOL]);

    always_comb
    begin
        if (parallel && control_two[`FMRX_CTRL_DMAEN] && dq.pop_valid)
        begin
            dma_request_o = control_two[`FMRX_CTRL_REQPOL];
        end
        else
        begin
            dma_request_o = !control_two[`FMRX_CTRL_REQPOL];
        end
    end

    // Strobe for DMA reads of the data port
    always_comb
    begin
        dma_strobe = 1'b0;
        if (parallel && control_two[`FMRX_CTRL_DMAEN])
        begin
            if (control_two[`FMRX_CTRL_DMARD])
            begin
                dma_strobe = ack_active;
            end
            else
            begin
                dma_strobe = rd_i && addr_i == `FMRX_OFF_DATA;
            end
        end
    end

    // Serial reads carry no register address and pop the data port
    assign host_pop = dma_strobe
        || (parallel && rd_i && addr_i == `FMRX_OFF_DATA)
        || (interface_select_i && ser_read_i);
    assign dq.pop_ready = host_pop;

    // Vertical slot suppression when no vertical correction ran
    assign suppress = vertical_slot_i && !vertical_done_i
        && !control_two[`FMRX_CTRL_VOUT];
    // With output-all set, horizontal data passes in the slot, uncorrectable blocks included
    assign accept = block_start_i && !suppress;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            drop_block <= 1'b0;
        end
        else if (block_start_i)
        begin
            drop_block <= suppress;
        end
    end

    // Dropped bytes are consumed so the core never stalls on them
    assign dq.push_valid = core_valid_i && !drop_block;
    assign dq.push_data = core_data_i;
    assign core_ready_o = drop_block || dq.push_ready;

    // Interrupt falls with each accepted block, rises when drained
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            int_n_o <= 1'b1;
        end
        else if (accept)
        begin
            int_n_o <= 1'b0;
        end
        else if (!dq.pop_valid && !core_valid_i)
        begin
            int_n_o <= 1'b1;
        end
    end

    // Latched status flags, refreshed on the same edge as the fall
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stat_q <= `FMRX_STAT_RST;
        end
        else if (accept)
        begin
            stat_q[`FMRX_STAT_VCORR] <= vertical_corrected_i;
            stat_q[`FMRX_STAT_BSYNC] <= block_sync_i && !block_sync_reset_o;
            stat_q[`FMRX_STAT_FSYNC] <= frame_sync_i;
            stat_q[`FMRX_STAT_ERR] <= uncorrectable_i;
            stat_q[`FMRX_STAT_PARITY] <= parity_block_i;
            stat_q[`FMRX_STAT_HEAD] <= head_block_i;
            stat_q[`FMRX_STAT_CRC] <= 1'b1;
            stat_q[`FMRX_STAT_RTIME] <= realtime_block_i;
        end
        else if (block_sync_reset_o)
        begin
            stat_q[`FMRX_STAT_BSYNC] <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            output_block_number <= `FMRX_NUM_RST;
        end
        else if (accept)
        begin
            output_block_number <= block_number_i;
        end
    end

    // Group CRC check register
    assign crc_load = parallel ? (wr_i && addr_i == `FMRX_OFF_CRC)
        : ser_crc_valid_i;
    assign crc_byte = parallel ? wdata_i : ser_crc_data_i;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            group_crc <= `FMRX_CRC_RST;
        end
        else if (group_crc_reset_i)
        begin
            group_crc <= `FMRX_CRC_RST;
        end
        else if (crc_load)
        begin
            group_crc <= crc_step(group_crc, crc_byte);
        end
    end

    // Live result, so it reads one right after reset
    assign group_crc_ok_o = (group_crc == `FMRX_CRC_RST);

    always_comb
    begin
        receive_status = stat_q;
        receive_status[`FMRX_STAT_CRC] = group_crc_ok_o;
    end

    // Read decode, reserved addresses read zero
    always_comb
    begin
        case (addr_i)
            `FMRX_OFF_DATA: next_rdata = dq.pop_valid ? dq.pop_data : 8'h00;
            `FMRX_OFF_STAT: next_rdata = receive_status;
            `FMRX_OFF_NUM: next_rdata = output_block_number;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (interface_select_i && ser_read_i)
        begin
            rdata_o <= dq.pop_valid ? dq.pop_data : 8'h00;
        end
        else if ((rd_i && parallel) || dma_strobe)
        begin
            rdata_o <= dma_strobe ? (dq.pop_valid ? dq.pop_data : 8'h00) : next_rdata;
        end
    end

    // Ready handshake; a read during a pulse is not re-armed
    always_comb
    begin
        case (rdy_state)
            RDY_IDLE:
            begin
                if (parallel && (rd_i || dma_strobe))
                begin
                    next_rdy_state = control_two[`FMRX_CTRL_RDYT] ? RDY_WAIT : RDY_DRIVE;
                end
                else
                begin
                    next_rdy_state = RDY_IDLE;
                end
            end
            RDY_WAIT: next_rdy_state = RDY_DRIVE;
            RDY_DRIVE: next_rdy_state = RDY_IDLE;
            default: next_rdy_state = RDY_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdy_state <= RDY_IDLE;
        end
        else
        begin
            rdy_state <= next_rdy_state;
        end
    end

    assign rdy_o = (rdy_state == RDY_DRIVE);

    property p_rsvd_zero;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && parallel && addr_i == `FMRX_OFF_CTRL_TWO) |=> !control_two[`FMRX_CTRL_RSVD];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

    property p_bsr;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && parallel && addr_i == `FMRX_OFF_CTRL_TWO)
            |=> block_sync_reset_o == $past(wdata_i[`FMRX_CTRL_BSR]);
    endproperty
    a_bsr: assert property (p_bsr) else $error("block sync reset not stored");

    property p_bsr_clear;
        @(posedge clk_i) disable iff (rst_i)
        block_sync_reset_o |=> !stat_q[`FMRX_STAT_BSYNC];
    endproperty
    a_bsr_clear: assert property (p_bsr_clear) else $error("block flag kept");

    property p_req_pol;
        @(posedge clk_i) disable iff (rst_i)
        (parallel && control_two[`FMRX_CTRL_DMAEN] && dq.pop_valid)
            |-> dma_request_o == control_two[`FMRX_CTRL_REQPOL];
    endproperty
    a_req_pol: assert property (p_req_pol) else $error("request polarity");

    property p_ack_pop;
        @(posedge clk_i) disable iff (rst_i)
        (parallel && control_two[`FMRX_CTRL_DMAEN] && control_two[`FMRX_CTRL_DMARD]
            && dma_acknowledge_i == control_two[`FMRX_CTRL_ACKPOL]) |-> dq.pop_ready;
    endproperty
    a_ack_pop: assert property (p_ack_pop) else $error("ack strobe lost");

    property p_rdy_t2;
        @(posedge clk_i) disable iff (rst_i)
        (rdy_state == RDY_IDLE && parallel && rd_i && control_two[`FMRX_CTRL_RDYT])
            |=> !rdy_o ##1 rdy_o;
    endproperty
    a_rdy_t2: assert property (p_rdy_t2) else $error("ready timing two");

    property p_suppress;
        @(posedge clk_i) disable iff (rst_i)
        (block_start_i && suppress) |=> $stable(output_block_number) && drop_block;
    endproperty
    a_suppress: assert property (p_suppress) else $error("suppressed block shown");

    property p_update;
        @(posedge clk_i) disable iff (rst_i)
        accept |=> !int_n_o && output_block_number == $past(block_number_i)
            && stat_q[`FMRX_STAT_ERR] == $past(uncorrectable_i);
    endproperty
    a_update: assert property (p_update) else $error("status not updated");

    property p_rsvd_read;
        @(posedge clk_i) disable iff (rst_i)
        (rd_i && parallel && !dma_strobe && addr_i >= `FMRX_OFF_RSVD_LO) |=> rdata_o == 8'h00;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read");

    property p_crc_ok;
        @(posedge clk_i) disable iff (rst_i)
        group_crc_reset_i |=> group_crc_ok_o && receive_status[`FMRX_STAT_CRC];
    endproperty
    a_crc_ok: assert property (p_crc_ok) else $error("crc not cleared");

    property p_crc_step;
        @(posedge clk_i) disable iff (rst_i)
        (crc_load && !group_crc_reset_i)
            |=> group_crc == crc_step($past(group_crc), $past(crc_byte));
    endproperty
    a_crc_step: assert property (p_crc_step) else $error("crc step wrong");
endmodule : fm_data_rx_ctrl_status_regs

// ===== sim/dma_host_model.sv
// DMA controller stand-in: one acknowledge pulse per active request.
// Assumes the bench sets both polarities and drives from the falling edge.
`timescale 1ns/1ps
module dma_host_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic ack_pol_i,
    input wire logic req_pol_i,
    input wire logic req_i,
    output logic ack_o
);
    logic [1:0] gap;
    // Gap lets the popped byte clear the request before looking again
    always @(negedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b1;
            gap <= 2'h0;
        end
        else if (en_i && gap == 2'h0 && req_i == req_pol_i)
        begin
            ack_o <= ack_pol_i;
            gap <= 2'h3;
        end
        else
        begin
            ack_o <= !ack_pol_i;
            gap <= (gap == 2'h0) ? 2'h0 : gap - 2'h1;
        end
    end
endmodule : dma_host_model

// ===== sim/test_fm_data_rx_ctrl_status_regs.sv
// Self-checking bench for the receiver register bank with a DMA stand-in.
// Assumes strobes taken on the rising edge and answers one cycle later.
`timescale 1ns/1ps
`include "fmrx_params.svh"
module test_fm_data_rx_ctrl_status_regs;
    import fmrx_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sel = 1'b0;
    logic [3:0] addr = 4'h0;
    byte_t wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    byte_t rdata;
    logic rdy, ack, req, crc_ok, bsr, int_n, core_ready;
    logic scv = 1'b0;
    byte_t scd = 8'h00;
    logic crc_rst = 1'b0;
    logic srd = 1'b0;
    byte_t cdata = 8'h00;
    logic cvalid = 1'b0;
    logic bstart = 1'b0;
    logic vslot = 1'b0;
    logic vdone = 1'b0;
    logic [6:0] fl = 7'h00;
    byte_t bn = 8'h00;
    logic dma_en = 1'b0;
    byte_t ctl = 8'h00;
    byte_t exp_stat = 8'h02;
    byte_t exp_bn = 8'h00;
    crc_t crc = 16'h0000;
    crc_t tail;
    byte_t q[$];
    int error_cnt = 0;
    int n_compared = 0;

    always #12.5 clk_i = ~clk_i;

    fm_data_rx_ctrl_status_regs u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .interface_select_i(sel), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .rdy_o(rdy), .dma_acknowledge_i(ack), .dma_request_o(req),
        .ser_crc_valid_i(scv), .ser_crc_data_i(scd), .ser_read_i(srd),
        .group_crc_reset_i(crc_rst), .group_crc_ok_o(crc_ok), .block_sync_reset_o(bsr),
        .core_data_i(cdata), .core_valid_i(cvalid), .core_ready_o(core_ready),
        .block_start_i(bstart), .vertical_slot_i(vslot), .vertical_done_i(vdone),
        .vertical_corrected_i(fl[6]), .block_sync_i(fl[5]), .frame_sync_i(fl[4]),
        .uncorrectable_i(fl[3]), .parity_block_i(fl[2]), .head_block_i(fl[1]),
        .realtime_block_i(fl[0]), .block_number_i(bn), .int_n_o(int_n));

    dma_host_model u_host (.clk_i(clk_i), .rst_i(rst_i), .en_i(dma_en),
        .ack_pol_i(ctl[`FMRX_CTRL_ACKPOL]), .req_pol_i(ctl[`FMRX_CTRL_REQPOL]),
        .req_i(req), .ack_o(ack));

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic wr_reg(input logic [3:0] a, input byte_t d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_i);
        wr = 1'b0;
        if (a == `FMRX_OFF_CTRL_TWO)
            ctl = d;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, input byte_t e, input string what);
        addr = a;
        rd = 1'b1;
        @(negedge clk_i);
        rd = 1'b0;
        chk(what, rdata, e);
        chk("rdy_first", rdy, !ctl[`FMRX_CTRL_RDYT]);
        @(negedge clk_i);
        chk("rdy_second", rdy, ctl[`FMRX_CTRL_RDYT]);
        // Busy ready state ignores a read issued too soon
        if (ctl[`FMRX_CTRL_RDYT])
            @(negedge clk_i);
    endtask : rd_reg

    task automatic crc_byte(input byte_t b);
        for (int i = 7; i >= 0; i--)
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? `FMRX_CRC_POLY : 16'h0000);
        if (sel)
        begin
            scd = b;
            scv = 1'b1;
            @(negedge clk_i);
            scv = 1'b0;
        end
        else
            wr_reg(`FMRX_OFF_CRC, b);
        @(negedge clk_i);
        chk("crc_ok", crc_ok, crc == 16'h0000);
    endtask : crc_byte

    task automatic push(input byte_t b);
        int k;
        cdata = b;
        cvalid = 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (core_ready !== 1'b1 && k < 40);
        @(negedge clk_i);
    endtask : push

    task automatic run_block(input int n, input logic vs, input logic vd);
        logic keep;
        keep = !(vs && !vd && !ctl[`FMRX_CTRL_VOUT]);
        fl = 7'($urandom);
        bn = 8'($urandom);
        vslot = vs;
        vdone = vd;
        bstart = 1'b1;
        @(negedge clk_i);
        bstart = 1'b0;
        chk("int_n_block", int_n, !keep);
        if (keep)
        begin
            exp_stat = {fl[6], fl[5] & !ctl[`FMRX_CTRL_BSR], fl[4:1], 1'b0, fl[0]};
            exp_bn = bn;
        end
        for (int i = 0; i < n; i++)
        begin
            push(8'($urandom));
            if (keep)
                q.push_back(cdata);
        end
        cvalid = 1'b0;
        chk("core_ready", core_ready, q.size() < `FMRX_FIFO_DEPTH);
    endtask : run_block

    task automatic drain();
        exp_stat[`FMRX_STAT_CRC] = (crc == 16'h0000);
        chk("dma_req_off", req, !ctl[`FMRX_CTRL_REQPOL]);
        rd_reg(`FMRX_OFF_STAT, exp_stat, "status");
        rd_reg(`FMRX_OFF_NUM, exp_bn, "block_no");
        while (q.size() > 0)
            rd_reg(`FMRX_OFF_DATA, q.pop_front(), "data");
        chk("int_n_done", int_n, 1'b1);
        rd_reg(`FMRX_OFF_DATA, 8'h00, "data_empty");
    endtask : drain

    task automatic dma_pop();
        int k;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack !== ctl[`FMRX_CTRL_ACKPOL] && k < 20);
        @(negedge clk_i);
        chk("dma_data", rdata, q.pop_front());
    endtask : dma_pop

    initial
    begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        void'($urandom(32'h6628));
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        chk("int_n_rst", int_n, 1'b1);
        chk("crc_ok_rst", crc_ok, 1'b1);
        chk("bsr_rst", bsr, 1'b0);
        chk("req_rst", req, 1'b1);
        for (int a = 0; a < 16; a++)
            rd_reg(4'(a), (a == 1) ? `FMRX_STAT_RST : 8'h00, "reset_read");
        wr_reg(`FMRX_OFF_STAT, 8'hff);
        wr_reg(4'h9, 8'hff);
        rd_reg(`FMRX_OFF_STAT, `FMRX_STAT_RST, "ro_status");
        $display("test reset_and_map done");
        // Odd groups go over the serial path; the last group is left unfinished
        for (int g = 0; g < 4; g++)
        begin
            sel = g[0];
            crc_rst = 1'b1;
            @(negedge clk_i);
            crc_rst = 1'b0;
            crc = 16'h0000;
            chk("crc_ok_clr", crc_ok, 1'b1);
            repeat (1 + $urandom % 6) crc_byte(8'($urandom));
            tail = crc;
            if (g < 3)
            begin
                crc_byte(tail[15:8]);
                crc_byte(tail[7:0]);
            end
        end
        sel = 1'b0;
        exp_stat[`FMRX_STAT_CRC] = (crc == 16'h0000);
        rd_reg(`FMRX_OFF_STAT, exp_stat, "status_crc");
        $display("test group_crc done");
        wr_reg(`FMRX_OFF_CTRL_TWO, 8'h40);
        chk("bsr_on", bsr, 1'b1);
        run_block(3, 1'b0, 1'b0);
        drain();
        wr_reg(`FMRX_OFF_CTRL_TWO, 8'h00);
        chk("bsr_off", bsr, 1'b0);
        run_block(`FMRX_FIFO_DEPTH, 1'b0, 1'b0);
        drain();
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(`FMRX_OFF_CTRL_TWO, {4'h0, i[0], i[1], 2'b00});
            run_block(1 + $urandom % 5, 1'b1, i[2]);
            drain();
        end
        $display("test blocks done");
        // Serial pops carry no register address
        run_block(2, 1'b0, 1'b0);
        sel = 1'b1;
        while (q.size() > 0)
        begin
            srd = 1'b1;
            @(negedge clk_i);
            chk("ser_data", rdata, q.pop_front());
            srd = 1'b0;
            @(negedge clk_i);
        end
        sel = 1'b0;
        chk("int_n_ser", int_n, 1'b1);
        $display("test serial read done");
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(`FMRX_OFF_CTRL_TWO, {2'b00, i[0], i[1], 2'b00, i[2], 1'b1});
            run_block(1 + $urandom % 4, 1'b0, 1'b0);
            chk("dma_req_on", req, ctl[`FMRX_CTRL_REQPOL]);
            dma_en = ctl[`FMRX_CTRL_DMARD];
            while (q.size() > 0)
                if (dma_en)
                    dma_pop();
                else
                    rd_reg(`FMRX_OFF_DATA, q.pop_front(), "dma_rd");
            dma_en = 1'b0;
            repeat (4) @(negedge clk_i);
            chk("dma_req_idle", req, !ctl[`FMRX_CTRL_REQPOL]);
            chk("int_n_dma", int_n, 1'b1);
        end
        $display("test dma done");
        tally_and_finish();
    end
endmodule : test_fm_data_rx_ctrl_status_regs
